// *** include/tpwm_consts.svh ***
// register indices, field positions and reset values of the pwm timer pair
// assumes word-addressed avalon access, 16-bit data in the low half of each word
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH

// ----------------------------------------------------------------
// register word indices
// ----------------------------------------------------------------
`define TPWM_IDX_CTRL      4'h0
`define TPWM_IDX_COUNT     4'h1
`define TPWM_IDX_PERIOD    4'h2
`define TPWM_IDX_CH0_CTRL  4'h3
`define TPWM_IDX_CH0_CMP   4'h4
`define TPWM_IDX_CH1_CTRL  4'h5
`define TPWM_IDX_CH1_CMP   4'h6

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define TPWM_FLAG_BIT      7
`define TPWM_RST_BIT       4
`define TPWM_CTRL_RESET    8'h20
`define TPWM_CHAN_RESET    8'h00
`define TPWM_PERIOD_RESET  16'hffff
`define TPWM_CMP_RESET     16'h0000
`define TPWM_DIV_NONE      3'h7

`endif

// *** include/tpwm_pkg.sv ***
// types shared by the pwm timer pair
// assumes the constants header is compiled alongside
package tpwm_pkg;

	typedef struct packed {
		logic       flag;
		logic       irq_en;
		logic       halt;
		logic       rst;
		logic       spare;
		logic [2:0] div;
	} timer_ctrl_t;

	typedef struct packed {
		logic flag;
		logic irq_en;
		logic msb;
		logic msa;
		logic elsb;
		logic elsa;
		logic tov;
		logic max;
	} chan_ctrl_t;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ANS  = 1'b1
	} bus_state_t;

endpackage : tpwm_pkg

// *** tb/testbench.sv ***
// self-checking bench for the pwm timer pair: pwm shape, buffering, flags, low-power and break
// assumes the design answers every avalon access with exactly one wait state
`timescale 1ns/1ps
`include "tpwm_consts.svh"

module testbench;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic [3:0]  avs_address_in = 4'h0;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0]  avs_byteenable_in = 4'h3;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        wait_mode_in = 1'b0;
	logic        stop_mode_in = 1'b0;
	logic        break_in = 1'b0;
	logic        break_clear_enable_in = 1'b0;
	logic        irq_out, chan0_pin_out, chan0_pin_oe_out;
	logic        chan1_pin_out, chan1_pin_oe_out, chan1_gpio_out;
	int          errors = 0;
	int          cmp_count = 0;
	logic [31:0] rd, rd2;
	int          hi, edges;

	timer_pwm_channel_pair i_timer_pwm_channel_pair (.clk_in(clk_in), .srst_in(srst_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .wait_mode_in(wait_mode_in),
		.stop_mode_in(stop_mode_in), .break_in(break_in),
		.break_clear_enable_in(break_clear_enable_in), .irq_out(irq_out),
		.chan0_pin_out(chan0_pin_out), .chan0_pin_oe_out(chan0_pin_oe_out),
		.chan1_pin_out(chan1_pin_out), .chan1_pin_oe_out(chan1_pin_oe_out),
		.chan1_gpio_out(chan1_gpio_out));

	always #50 clk_in = ~clk_in;

	// ----------------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------------
	task automatic bus_access(input logic wr, input logic [3:0] a, input logic [15:0] d);
		int   n;
		logic w;
		n = 0;
		w = 1'b1;
		@(posedge clk_in);
		avs_address_in   <= a;
		avs_writedata_in <= {16'h0000, d};
		avs_write_in     <= wr;
		avs_read_in      <= ~wr;
		// request stays up until the edge that sees waitrequest low; the settled
		// mid-cycle value is what that edge samples, so no race with the slave's update
		while (w !== 1'b0 && n < 20) begin
			@(negedge clk_in);
			w  = avs_waitrequest_out;
			rd = avs_readdata_out;
			@(posedge clk_in);
			n++;
		end
		if (n >= 20) begin
			errors++;
			$display("CHECK FAILED %0t bus answer missing", $time);
		end
		avs_write_in <= 1'b0;
		avs_read_in  <= 1'b0;
	endtask : bus_access

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_cnt(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			errors++;
			$display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : check_cnt

	// a window of whole periods holds a phase-independent number of high cycles and edges
	task automatic measure(input int settle, input int n);
		logic last;
		repeat (settle) @(posedge clk_in);
		hi = 0;
		edges = 0;
		last = chan0_pin_out;
		repeat (n) begin
			@(negedge clk_in);
			if (chan0_pin_out === 1'b1) hi++;
			if (chan0_pin_out === 1'b1 && last === 1'b0) edges++;
			last = chan0_pin_out;
		end
	endtask : measure

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		bus_access(1'b0, `TPWM_IDX_CTRL, 16'h0);
		check_val(rd, 32'h0000_0020);
		bus_access(1'b0, `TPWM_IDX_PERIOD, 16'h0);
		check_val(rd, 32'h0000_ffff);
		bus_access(1'b0, `TPWM_IDX_CH0_CTRL, 16'h0);
		check_val(rd, 32'h0000_0000);
		bus_access(1'b0, `TPWM_IDX_COUNT, 16'h0);
		check_val(rd, 32'h0000_0000);
		bus_access(1'b1, 4'h9, 16'h1234);
		bus_access(1'b0, 4'h9, 16'h0);
		check_val(rd, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_pwm;
		bus_access(1'b1, `TPWM_IDX_CTRL, 16'h0030);
		bus_access(1'b1, `TPWM_IDX_PERIOD, 16'h0009);
		bus_access(1'b1, `TPWM_IDX_CH0_CMP, 16'h0005);
		bus_access(1'b1, `TPWM_IDX_CH0_CTRL, 16'h001a);
		bus_access(1'b1, `TPWM_IDX_CTRL, 16'h0000);
		measure(30, 40);
		check_cnt(edges, 4);
		check_cnt(hi, 20);
		check_val({31'h0, chan0_pin_oe_out}, 32'h1);
		bus_access(1'b0, `TPWM_IDX_CH0_CTRL, 16'h0);
		check_val(rd & 32'h80, 32'h80);
		bus_access(1'b1, `TPWM_IDX_CTRL, 16'h0001);
		measure(40, 80);
		check_cnt(edges, 4);
		check_cnt(hi, 40);
		bus_access(1'b1, `TPWM_IDX_CTRL, 16'h0000);
		bus_access(1'b1, `TPWM_IDX_CH0_CMP, 16'h0003);
		measure(30, 40);
		check_cnt(hi, 12);
		bus_access(1'b1, `TPWM_IDX_CH0_CTRL, 16'h0018);
		measure(20, 40);
		check_cnt(hi, 0);
		bus_access(1'b1, `TPWM_IDX_CH0_CTRL, 16'h001b);
		measure(20, 40);
		check_cnt(hi, 40);
		$display("test pwm done");
	endtask : t_pwm

	task automatic t_buffered;
		bus_access(1'b1, `TPWM_IDX_CH0_CMP, 16'h0005);
		bus_access(1'b1, `TPWM_IDX_CH0_CTRL, 16'h003a);
		bus_access(1'b1, `TPWM_IDX_CH1_CTRL, 16'h001a);
		bus_access(1'b0, `TPWM_IDX_CH1_CTRL, 16'h0);
		check_val(rd, 32'h0);
		check_val({30'h0, chan1_gpio_out, chan1_pin_oe_out}, 32'h2);
		measure(20, 40);
		check_cnt(hi, 20);
		bus_access(1'b1, `TPWM_IDX_CH1_CMP, 16'h0002);
		measure(30, 40);
		check_cnt(hi, 8);
		bus_access(1'b1, `TPWM_IDX_CH0_CMP, 16'h0007);
		measure(30, 40);
		check_cnt(hi, 28);
		bus_access(1'b1, `TPWM_IDX_CH0_CTRL, 16'h001a);
		$display("test buffered done");
	endtask : t_buffered

	task automatic t_flags;
		bus_access(1'b1, `TPWM_IDX_CTRL, 16'h0040);
		repeat (20) @(posedge clk_in);
		check_val({31'h0, irq_out}, 32'h1);
		// halting first keeps new wrap events out of the clear sequence
		bus_access(1'b1, `TPWM_IDX_CTRL, 16'h0060);
		bus_access(1'b0, `TPWM_IDX_CTRL, 16'h0);
		check_val(rd, 32'h00e0);
		break_in <= 1'b1;
		bus_access(1'b1, `TPWM_IDX_CTRL, 16'h0060);
		bus_access(1'b0, `TPWM_IDX_CTRL, 16'h0);
		check_val(rd, 32'h00e0);
		break_in <= 1'b0;
		bus_access(1'b1, `TPWM_IDX_CTRL, 16'h0060);
		bus_access(1'b0, `TPWM_IDX_CTRL, 16'h0);
		check_val(rd, 32'h0060);
		check_val({31'h0, irq_out}, 32'h0);
		$display("test flags done");
	endtask : t_flags

	task automatic t_modes;
		bus_access(1'b1, `TPWM_IDX_CTRL, 16'h0000);
		stop_mode_in <= 1'b1;
		bus_access(1'b0, `TPWM_IDX_COUNT, 16'h0);
		rd2 = rd;
		repeat (13) @(posedge clk_in);
		bus_access(1'b0, `TPWM_IDX_COUNT, 16'h0);
		check_val(rd, rd2);
		stop_mode_in <= 1'b0;
		break_in <= 1'b1;
		bus_access(1'b0, `TPWM_IDX_COUNT, 16'h0);
		rd2 = rd;
		repeat (13) @(posedge clk_in);
		bus_access(1'b0, `TPWM_IDX_COUNT, 16'h0);
		check_val(rd, rd2);
		break_in <= 1'b0;
		wait_mode_in <= 1'b1;
		bus_access(1'b1, `TPWM_IDX_PERIOD, 16'h0003);
		bus_access(1'b0, `TPWM_IDX_PERIOD, 16'h0);
		check_val(rd, 32'h0);
		wait_mode_in <= 1'b0;
		bus_access(1'b0, `TPWM_IDX_PERIOD, 16'h0);
		check_val(rd, 32'h0009);
		$display("test modes done");
	endtask : t_modes

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_in);
		srst_in <= 1'b0;
		t_reset();
		t_pwm();
		t_buffered();
		t_flags();
		t_modes();
		finish_test();
	end

	initial begin
		#5000000;
		errors++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		finish_test();
	end
endmodule : testbench

// *** verilog/timer_pwm_channel_pair.sv ***
// 16-bit timer with two compare/pwm channels, buffered pairing and flag handshakes
// assumes an avalon-mm master on clk_in and low-power/break levels synchronous to clk_in
//
// Contract
// - toggle-on-wrap flips pin at period limit
// - pulse spans wrap to compare match
// - period is limit plus one timer ticks
// - duty is compare over period count
// - unbuffered compare uses register immediately
// - channel 0 buffered bit links pair
// - channel 1 takes over at next period
// - each wrap selects last written compare
// - channel 0 control governs; pin 1 freed
// - edge/level 10 clears, 11 sets output
// - toggle off gives constant zero duty
// - full duty bit plus toggle holds active
// - wrap sets flag; irq gated by enable
// - compare sets channel flag; irq if enabled
// - wait mode counts, registers locked, irq wakes
// - stop mode halts, keeps all state
// - break freezes the counter
// - break protects flags unless clear enabled
// - counter restarts at zero after wrap
// - divider select 1..64, code 7 stops
// - flag clears by read-set then write-zero
`timescale 1ns/1ps
`include "tpwm_consts.svh"

module timer_pwm_channel_pair (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        wait_mode_in,
	input  wire logic        stop_mode_in,
	input  wire logic        break_in,
	input  wire logic        break_clear_enable_in,
	output logic             irq_out,
	output logic             chan0_pin_out,
	output logic             chan0_pin_oe_out,
	output logic             chan1_pin_out,
	output logic             chan1_pin_oe_out,
	output logic             chan1_gpio_out
);

	// ----------------------------------------------------------------
	// bus slave: one wait state, reads captured on the first cycle
	// ----------------------------------------------------------------
	tpwm_pkg::bus_state_t st_q;
	logic [15:0]          rdata_q;
	wire                  req     = avs_read_in | avs_write_in;
	wire                  idle    = (st_q == tpwm_pkg::BUS_IDLE);
	wire                  rd_cap  = avs_read_in & idle & ~wait_mode_in;
	wire                  wr_acc  = avs_write_in & ~idle & ~wait_mode_in;
	wire                  clr_ok  = ~break_in | break_clear_enable_in;
	wire [3:0]            adr     = avs_address_in;
	wire                  sel_ctl = (adr == `TPWM_IDX_CTRL);
	wire                  sel_per = (adr == `TPWM_IDX_PERIOD);
	wire [1:0]            sel_cc  = {adr == `TPWM_IDX_CH1_CTRL, adr == `TPWM_IDX_CH0_CTRL};
	wire [1:0]            sel_cmp = {adr == `TPWM_IDX_CH1_CMP, adr == `TPWM_IDX_CH0_CMP};
	wire [1:0]            be      = avs_byteenable_in[1:0];
	wire [15:0]           wd      = avs_writedata_in[15:0];

	assign avs_waitrequest_out = req & idle;
	assign avs_readdata_out    = {16'h0000, rdata_q};

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_q <= tpwm_pkg::BUS_IDLE;
		end else if (req & idle) begin
			st_q <= tpwm_pkg::BUS_ANS;
		end else begin
			st_q <= tpwm_pkg::BUS_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// timer control, prescaler and counter
	// ----------------------------------------------------------------
	tpwm_pkg::timer_ctrl_t tc_q;
	logic                  wrap_arm_q;
	logic [5:0]            pre_q;
	logic [15:0]           cnt_q;
	logic [15:0]           per_q;
	wire tpwm_pkg::timer_ctrl_t tc_w = tpwm_pkg::timer_ctrl_t'(wd[7:0]);
	wire                   wr_ctl   = wr_acc & sel_ctl & be[0];
	wire                   trst_w   = wr_ctl & wd[`TPWM_RST_BIT];
	wire                   run      = ~tc_q.halt & ~stop_mode_in & ~break_in;
	wire [5:0]             div_mask = 6'((7'h01 << tc_q.div) - 7'h01);
	wire                   tick     = run & (tc_q.div != `TPWM_DIV_NONE)
	                                  & ((pre_q & div_mask) == div_mask);
	wire                   wrap_ev  = tick & (cnt_q == per_q);
	wire [15:0]            cnt_nx   = wrap_ev ? 16'h0000 : 16'(cnt_q + 16'h0001);
	wire                   wrap_clr = wr_ctl & ~wd[`TPWM_FLAG_BIT] & wrap_arm_q & clr_ok;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pre_q <= 6'h00;
			cnt_q <= 16'h0000;
		end else if (trst_w) begin
			pre_q <= 6'h00;
			cnt_q <= 16'h0000;
		end else begin
			if (run)
				pre_q <= 6'(pre_q + 6'h01);
			if (tick)
				cnt_q <= cnt_nx;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tc_q       <= tpwm_pkg::timer_ctrl_t'(`TPWM_CTRL_RESET);
			per_q      <= `TPWM_PERIOD_RESET;
			wrap_arm_q <= 1'b0;
		end else begin
			// a new wrap beats a clear in the same cycle
			tc_q.flag <= wrap_ev | (tc_q.flag & ~wrap_clr);
			if (wr_ctl) begin
				tc_q.irq_en <= tc_w.irq_en;
				tc_q.halt   <= tc_w.halt;
				tc_q.div    <= tc_w.div;
			end
			if (wr_acc & sel_per & be[0])
				per_q[7:0] <= wd[7:0];
			if (wr_acc & sel_per & be[1])
				per_q[15:8] <= wd[15:8];
			if (wrap_ev)
				wrap_arm_q <= 1'b0;
			else if (rd_cap & sel_ctl & tc_q.flag & clr_ok)
				wrap_arm_q <= 1'b1;
			else if (wr_ctl & clr_ok)
				wrap_arm_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// channels; channel 0 may own both compare registers
	// ----------------------------------------------------------------
	logic [1:0][15:0] cmp_all;
	logic [1:0][7:0]  cc_all;
	logic [1:0]       oc_v;
	logic [1:0]       cmp_ev;
	logic [1:0]       out_v;
	logic [1:0]       full_v;
	logic [1:0]       act_v;
	logic             last_wr_q;
	logic             act_sel_q;
	wire              buffered = cc_all[0][5];
	wire [1:0]        en_v     = {~buffered, 1'b1};
	wire [1:0]        wr_cmp   = {2{wr_acc & (be[0] | be[1])}} & sel_cmp;

	always_ff @(posedge clk_in) begin
		if (srst_in | ~buffered) begin
			last_wr_q <= 1'b0;
			act_sel_q <= 1'b0;
		end else begin
			if (wr_cmp[1])
				last_wr_q <= 1'b1;
			else if (wr_cmp[0])
				last_wr_q <= 1'b0;
			if (wrap_ev)
				act_sel_q <= last_wr_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_chan
			tpwm_pkg::chan_ctrl_t cc_q;
			logic [15:0]          cmp_q;
			logic                 out_q;
			logic                 arm_q;
			logic                 t_d;
			wire tpwm_pkg::chan_ctrl_t cw = tpwm_pkg::chan_ctrl_t'(wd[7:0]);
			wire [15:0] cmp_use = (i == 0 && buffered && act_sel_q) ? cmp_all[1] : cmp_q;
			wire        drive   = cc_q.elsb | cc_q.elsa;
			wire        oc      = en_v[i] & drive & (cc_q.msa | cc_q.msb);
			wire        ev      = oc & tick & (cnt_nx == cmp_use);
			wire        wr_cc   = wr_acc & sel_cc[i] & be[0] & en_v[i];
			wire        clr     = wr_cc & ~cw.flag & arm_q & clr_ok;

			always_comb begin
				t_d = out_q;
				if (wrap_ev & cc_q.tov)
					t_d = ~t_d;
				if (ev) begin
					case ({cc_q.elsb, cc_q.elsa})
						2'b01:   t_d = ~t_d;
						2'b10:   t_d = 1'b0;
						2'b11:   t_d = 1'b1;
						default: t_d = out_q;
					endcase
				end
			end

			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					cc_q  <= tpwm_pkg::chan_ctrl_t'(`TPWM_CHAN_RESET);
					cmp_q <= `TPWM_CMP_RESET;
					out_q <= 1'b0;
					arm_q <= 1'b0;
				end else begin
					cc_q.flag <= ev | (cc_q.flag & ~clr);
					if (wr_cc) begin
						cc_q.irq_en <= cw.irq_en;
						cc_q.msb    <= (i == 0) ? cw.msb : 1'b0;
						cc_q.msa    <= cw.msa;
						cc_q.elsb   <= cw.elsb;
						cc_q.elsa   <= cw.elsa;
						cc_q.tov    <= cw.tov;
						cc_q.max    <= cw.max;
					end
					if (wr_cmp[i] & be[0])
						cmp_q[7:0] <= wd[7:0];
					if (wr_cmp[i] & be[1])
						cmp_q[15:8] <= wd[15:8];
					if (ev)
						arm_q <= 1'b0;
					else if (rd_cap & sel_cc[i] & cc_q.flag & clr_ok & en_v[i])
						arm_q <= 1'b1;
					else if (wr_cc & clr_ok)
						arm_q <= 1'b0;
					if (!drive)
						out_q <= ~cc_q.msa;
					else if (oc & cc_q.max & cc_q.tov)
						out_q <= ~cc_q.elsa;
					else if (oc)
						out_q <= t_d;
				end
			end

			assign cmp_all[i] = cmp_q;
			assign cc_all[i]  = cc_q;
			assign oc_v[i]    = oc;
			assign cmp_ev[i]  = ev;
			assign out_v[i]   = out_q;
			assign full_v[i]  = cc_q.max & cc_q.tov;
			assign act_v[i]   = ~cc_q.elsa;
		end
	endgenerate

	// ----------------------------------------------------------------
	// read mux, pins and interrupt
	// ----------------------------------------------------------------
	wire [7:0]  cc1_rd = en_v[1] ? cc_all[1] : 8'h00;
	wire [15:0] rd_mux = sel_ctl                    ? {8'h00, tc_q} :
	                     (adr == `TPWM_IDX_COUNT)   ? cnt_q :
	                     sel_per                    ? per_q :
	                     sel_cc[0]                  ? {8'h00, cc_all[0]} :
	                     sel_cmp[0]                 ? cmp_all[0] :
	                     sel_cc[1]                  ? {8'h00, cc1_rd} :
	                     sel_cmp[1]                 ? cmp_all[1] : 16'h0000;
	wire [1:0]  ch_irq = {cc_all[1][7] & cc_all[1][6], cc_all[0][7] & cc_all[0][6]} & en_v;

	always_ff @(posedge clk_in) begin
		if (srst_in)
			rdata_q <= 16'h0000;
		else if (req & idle)
			rdata_q <= rd_cap ? rd_mux : 16'h0000;
	end

	// the irq stays live in wait mode so any enabled source wakes the core
	assign irq_out          = (tc_q.flag & tc_q.irq_en) | (|ch_irq);
	assign chan0_pin_out    = out_v[0];
	assign chan0_pin_oe_out = oc_v[0];
	assign chan1_pin_out    = out_v[1];
	assign chan1_pin_oe_out = oc_v[1];
	assign chan1_gpio_out   = buffered;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	a_wrap_restart: assert property (wrap_ev |-> cnt_q == per_q ##1 cnt_q == 16'h0000)
		else $error("counter did not restart from zero after wrap");
	a_wrap_flag_set: assert property (wrap_ev |=> tc_q.flag)
		else $error("wrap flag not set on wrap");
	a_irq_gate: assert property (irq_out |-> (tc_q.flag & tc_q.irq_en) | (|ch_irq))
		else $error("irq raised without an enabled flag");
	a_chan_flag_set: assert property (cmp_ev[0] |=> cc_all[0][7])
		else $error("channel 0 flag not set on compare");
	a_halt_freeze: assert property (!run && !trst_w |=> cnt_q == $past(cnt_q))
		else $error("counter moved while halted");
	a_full_duty_hold: assert property (oc_v[0] && full_v[0] |=> out_v[0] == $past(act_v[0]))
		else $error("full duty output not at active level");
	a_buf_select: assert property (buffered && wrap_ev |=> act_sel_q == $past(last_wr_q))
		else $error("buffered pair did not switch to last written compare");
	a_zero_duty: assert property (oc_v[0] && !full_v[0] && !cc_all[0][1] && !cmp_ev[0]
		|=> out_v[0] == $past(out_v[0]))
		else $error("output changed with toggle off and no compare");
	a_flag_needs_arm: assert property (tc_q.flag && !wrap_arm_q |=> tc_q.flag)
		else $error("wrap flag cleared without a prior read");
	a_wait_lock: assert property (wait_mode_in && avs_write_in && sel_per && !idle
		|=> per_q == $past(per_q))
		else $error("register written during wait mode");

	c_wrap:      cover property (wrap_ev ##1 tc_q.flag);
	c_buf_swap:  cover property (buffered && wrap_ev && last_wr_q);
	c_flag_clr:  cover property (tc_q.flag ##1 !tc_q.flag);
	c_pwm_pulse: cover property (oc_v[0] && out_v[0] ##[1:300] !out_v[0]);

endmodule : timer_pwm_channel_pair
